//--- mbrs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - driver serial port is full duplex, synchronous, one byte per transfer.
// - serial link uses select, clock, data out, data in and interrupt request.
// - each driver chip has its own active-low serial select.
// - each driver gets strobe, count select, level select and group address.
// - waveform order set by select lines, timed by strobe, chosen by array type.
// - direct pulse only after the group is fully loaded.
// - release pulse relaxes mirrors, waits for load, then latches.
// - array loads and resets as 15 blocks of 72 rows.
// - first and last 64 pixels of every row are not visible.
// - four reset modes: single, dual, quad and global.
// - single mode resets any one loaded block, any order.
// - dual mode pairs 0-1 through 12-13, block 14 alone.
// - quad mode groups 0-3, 4-7, 8-11 and 12-14.
// - global mode resets all blocks, whole array loaded first.
module mbrs_sequencer #(
  parameter int         INIT_CYCLES = mbrs_pkg::INIT_CYC,
  parameter logic [3:0] TYPE_FAST   = 4'h3, // arbitrary value
  parameter logic [3:0] TYPE_SLOW   = 4'h5  // arbitrary value
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        cmdValid,
  input  wire logic [1:0]                  blockCommandModeSelect,
  input  wire logic [3:0]                  blockAddressPointer,
  input  wire logic                        withRelease,
  output logic                             cmdAccepted,
  output logic                             cmdRejected,
  output logic                             resetActive,
  output logic                             initActive,
  input  wire logic [3:0]                  arrayType,
  input  wire logic                        rowWrite,
  input  wire logic [10:0]                 rowAddr,
  output logic [14:0]                      loadedMask,
  input  wire logic [10:0]                 pixelCol,
  output logic                             pixelVisible,
  input  wire logic                        serValid,
  input  wire logic                        serTarget,
  input  wire logic [7:0]                  serByte,
  output logic                             serReady,
  output logic [7:0]                       serRxByte,
  output logic                             serRxValid,
  output logic                             driverASerialSelect_n,
  output logic                             driverBSerialSelect_n,
  output logic                             driverSerialClock,
  output logic                             driverSerialDataIn,
  input  wire logic                        driverSerialDataOut,
  input  wire logic                        driverIrq,
  output logic                             driverIrqSeen,
  output mbrs_pkg::mbrs_drv_s [1:0]        drvCtl
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_SETTLE, ST_WAIT} mbrs_state_e;

  mbrs_state_e         state;
  mbrs_state_e         next_state;
  logic [7:0]          timer;
  logic [7:0]          next_timer;
  logic [1:0]          step;
  logic [1:0]          next_step;
  logic [14:0]         grpMask;
  logic [1:0]          grpCount;
  logic [3:0]          grpFirst;
  logic                isRelease;
  logic [7:0]          settleCyc;
  logic [23:0]         initCnt;
  logic                serBusy;
  mbrs_pkg::mbrs_mode_e modeIn;
  logic [14:0]         newMask;
  logic [3:0]          newFirst;
  logic                newLoaded;
  logic                typeOk;
  logic                accept;
  logic                grpLoaded;
  logic [1:0]          stepLevel;
  logic [1:0]          lastStep;
  logic [1:0]          inDrv;
  logic [3:0]          drvAddr [2];

  // =====================================================
  // command decode
  assign modeIn = mbrs_pkg::mbrs_mode_e'(blockCommandModeSelect);

  genvar gi;
  generate
    for (gi = 0; gi < mbrs_pkg::NUM_BLOCKS; gi++) begin : g_grp
      localparam logic [3:0] IDX = 4'(gi);
      assign newMask[gi] = (modeIn == mbrs_pkg::MODE_SINGLE && IDX == blockAddressPointer)
        || (modeIn == mbrs_pkg::MODE_DUAL && IDX[3:1] == blockAddressPointer[3:1])
        || (modeIn == mbrs_pkg::MODE_QUAD && IDX[3:2] == blockAddressPointer[3:2])
        || modeIn == mbrs_pkg::MODE_GLOBAL;
    end
  endgenerate

  assign newFirst = modeIn == mbrs_pkg::MODE_SINGLE ? blockAddressPointer
                  : modeIn == mbrs_pkg::MODE_DUAL ? {blockAddressPointer[3:1], 1'b0}
                  : modeIn == mbrs_pkg::MODE_QUAD ? {blockAddressPointer[3:2], 2'b00}
                  : 4'h0;
  assign newLoaded = (loadedMask & newMask) == newMask;
  assign grpLoaded = (loadedMask & grpMask) == grpMask;
  assign typeOk    = arrayType == TYPE_FAST || arrayType == TYPE_SLOW;
  assign accept    = cmdValid && state == ST_IDLE && !initActive && typeOk
                   && newMask != 15'h0000 && (withRelease || newLoaded);
  assign cmdAccepted = accept;
  assign cmdRejected = cmdValid && !accept;

  // =====================================================
  // waveform step levels
  assign stepLevel = step == 2'd0 ? 2'(mbrs_pkg::LVL_PULSE)
                   : (step == 2'd1 && isRelease) ? 2'(mbrs_pkg::LVL_OFFSET)
                   : 2'(mbrs_pkg::LVL_HOLD);
  assign lastStep  = isRelease ? 2'd2 : 2'd1;

  // =====================================================
  // pulse sequencer
  always_comb begin
    next_state = state;
    next_step  = step;
    next_timer = timer != 8'h00 ? timer - 8'h01 : 8'h00;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_SETUP;
          next_timer = mbrs_pkg::SETUP_CYC;
          next_step  = 2'd0;
        end
      end
      ST_SETUP: begin
        if (timer == 8'h01) begin
          next_state = ST_STROBE;
          next_timer = mbrs_pkg::STROBE_CYC;
        end
      end
      ST_STROBE: begin
        if (timer == 8'h01) begin
          next_state = ST_SETTLE;
          next_timer = settleCyc;
        end
      end
      ST_SETTLE: begin
        if (timer == 8'h01) begin
          if (step == lastStep) begin
            next_state = ST_IDLE;
          end else begin
            next_step = step + 2'd1;
            if (isRelease && step == 2'd1) begin
              next_state = ST_WAIT;
            end else begin
              next_state = ST_SETUP;
              next_timer = mbrs_pkg::SETUP_CYC;
            end
          end
        end
      end
      ST_WAIT: begin
        if (grpLoaded) begin
          next_state = ST_SETUP;
          next_timer = mbrs_pkg::SETUP_CYC;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      timer       <= 8'h00;
      step        <= 2'd0;
      resetActive <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      step        <= next_step;
      resetActive <= next_state != ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      grpMask   <= 15'h0000;
      grpCount  <= 2'(mbrs_pkg::CNT_ONE);
      grpFirst  <= 4'h0;
      isRelease <= 1'b0;
      settleCyc <= mbrs_pkg::SETTLE_A_CYC;
    end else if (accept) begin
      grpMask   <= newMask;
      grpCount  <= blockCommandModeSelect;
      grpFirst  <= newFirst;
      isRelease <= withRelease;
      settleCyc <= arrayType == TYPE_FAST ? mbrs_pkg::SETTLE_A_CYC
                                          : mbrs_pkg::SETTLE_B_CYC;
    end
  end

  // =====================================================
  // driver control lines, one registered set per chip
  assign inDrv[0]   = |grpMask[7:0];
  assign inDrv[1]   = |grpMask[14:8];
  assign drvAddr[0] = grpFirst;
  assign drvAddr[1] = grpFirst >= mbrs_pkg::BLOCKS_ON_A
                    ? grpFirst - mbrs_pkg::BLOCKS_ON_A : 4'h0;

  genvar gd;
  generate
    for (gd = 0; gd < mbrs_pkg::NUM_DRIVERS; gd++) begin : g_drv
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          drvCtl[gd] <= '0;
        end else begin
          drvCtl[gd].strobe <= state == ST_STROBE && inDrv[gd];
          if (state == ST_SETUP && inDrv[gd]) begin
            drvCtl[gd].countSel  <= grpCount;
            drvCtl[gd].levelSel  <= stepLevel;
            drvCtl[gd].groupAddr <= drvAddr[gd];
          end
        end
      end

      property p_stable;
        @(posedge core_clk) disable iff (!rst_b)
          drvCtl[gd].strobe |-> $stable(drvCtl[gd][7:0]);
      endproperty
      a_stable: assert property (p_stable) else $error("driver lines moved during strobe");

      property p_width;
        @(posedge core_clk) disable iff (!rst_b)
          $rose(drvCtl[gd].strobe) |-> drvCtl[gd].strobe [*4] ##1 !drvCtl[gd].strobe;
      endproperty
      a_width: assert property (p_width) else $error("strobe width wrong");
    end
  endgenerate

  // =====================================================
  // load tracking, init, visibility, serial port
  mbrs_load_tracker u_load (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .rowWrite   (rowWrite),
    .rowAddr    (rowAddr),
    .clearMask  (accept ? newMask : 15'h0000),
    .loadedMask (loadedMask)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      initActive    <= 1'b1;
      initCnt       <= 24'h000000;
      pixelVisible  <= 1'b0;
      driverIrqSeen <= 1'b0;
    end else begin
      if (initActive) begin
        initCnt <= initCnt + 24'h000001;
        if (initCnt == 24'(INIT_CYCLES - 1)) begin
          initActive <= 1'b0;
        end
      end
      pixelVisible  <= pixelCol >= 11'(mbrs_pkg::HIDDEN_PIXELS)
        && pixelCol < 11'(mbrs_pkg::ROW_PIXELS - mbrs_pkg::HIDDEN_PIXELS);
      driverIrqSeen <= driverIrq;
    end
  end

  assign serReady = !serBusy;

  mbrs_serial_port u_ser (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (serValid && !serBusy),
    .target   (serTarget),
    .txByte   (serByte),
    .busy     (serBusy),
    .rxByte   (serRxByte),
    .rxValid  (serRxValid),
    .selA_n   (driverASerialSelect_n),
    .selB_n   (driverBSerialSelect_n),
    .sclk     (driverSerialClock),
    .sdo      (driverSerialDataIn),
    .sdi      (driverSerialDataOut)
  );

  // =====================================================
  // checks
  property p_direct_loaded;
    @(posedge core_clk) disable iff (!rst_b)
      cmdValid && !withRelease && modeIn == mbrs_pkg::MODE_SINGLE
        && (loadedMask & 15'(1 << blockAddressPointer)) == 15'h0000 |-> cmdRejected;
  endproperty
  a_direct_loaded: assert property (p_direct_loaded) else $error("direct pulse unloaded");

  property p_active_span;
    @(posedge core_clk) disable iff (!rst_b)
      cmdAccepted |=> resetActive [*8];
  endproperty
  a_active_span: assert property (p_active_span) else $error("reset active dropped");

  property p_release_wait;
    @(posedge core_clk) disable iff (!rst_b)
      state == ST_WAIT && !grpLoaded |=> state == ST_WAIT && !drvCtl[0].strobe;
  endproperty
  a_release_wait: assert property (p_release_wait) else $error("latched before load");

  property p_hidden;
    @(posedge core_clk) disable iff (!rst_b)
      pixelCol < 11'd64 || pixelCol >= 11'd1856 |=> !pixelVisible;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden pixel shown");

  property p_dual_last;
    @(posedge core_clk) disable iff (!rst_b)
      cmdAccepted && modeIn == mbrs_pkg::MODE_DUAL && blockAddressPointer == 4'hE
        |=> grpMask == 15'h4000;
  endproperty
  a_dual_last: assert property (p_dual_last) else $error("dual group 14 wrong");

  property p_quad_last;
    @(posedge core_clk) disable iff (!rst_b)
      cmdAccepted && modeIn == mbrs_pkg::MODE_QUAD && blockAddressPointer[3:2] == 2'b11
        |=> grpMask == 15'h7000 && grpFirst == 4'hC;
  endproperty
  a_quad_last: assert property (p_quad_last) else $error("quad group 12-14 wrong");

  property p_init_block;
    @(posedge core_clk) disable iff (!rst_b)
      initActive |-> !cmdAccepted;
  endproperty
  a_init_block: assert property (p_init_block) else $error("command during init");
endmodule
`default_nettype wire

//--- mbrs_pkg.sv
`default_nettype none
package mbrs_pkg;
  // =====================================================
  // array geometry
  localparam int        NUM_BLOCKS     = 15;
  localparam int        ROWS_PER_BLOCK = 72;
  localparam int        NUM_ROWS       = 1080;
  localparam int        ROW_PIXELS     = 1920;
  localparam int        HIDDEN_PIXELS  = 64;
  localparam int        NUM_DRIVERS    = 2;
  localparam logic [3:0] BLOCKS_ON_A   = 4'h8;
  // =====================================================
  // timing
  localparam int        CLK_NS         = 25;
  localparam int        SETUP_NS       = 50;
  localparam int        STROBE_NS      = 100;
  localparam int        SETTLE_A_NS    = 2000;
  localparam int        SETTLE_B_NS    = 3000;
  localparam int        SER_HALF_NS    = 100;
  localparam int        INIT_MS        = 220;
  localparam logic [7:0] SETUP_CYC     = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC    = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETTLE_A_CYC  = 8'((SETTLE_A_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETTLE_B_CYC  = 8'((SETTLE_B_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SER_HALF_CYC  = 4'((SER_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam int        INIT_CYC       = INIT_MS * 1000000 / CLK_NS;
  // =====================================================
  // encodings
  typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_QUAD, MODE_GLOBAL} mbrs_mode_e;
  typedef enum logic [1:0] {CNT_ONE, CNT_TWO, CNT_FOUR, CNT_ALL} mbrs_count_e;
  typedef enum logic [1:0] {LVL_HOLD, LVL_OFFSET, LVL_PULSE} mbrs_level_e;
  typedef struct packed {
    logic       strobe;
    logic [1:0] countSel;
    logic [1:0] levelSel;
    logic [3:0] groupAddr;
  } mbrs_drv_s;
endpackage
`default_nettype wire

//--- mbrs_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module mbrs_serial_port (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic       target,
  input  wire logic [7:0] txByte,
  output logic            busy,
  output logic [7:0]      rxByte,
  output logic            rxValid,
  output logic            selA_n,
  output logic            selB_n,
  output logic            sclk,
  output logic            sdo,
  input  wire logic       sdi
);
  logic       active;
  logic       tgt;
  logic [7:0] shiftOut;
  logic [7:0] shiftIn;
  logic [2:0] bitCnt;
  logic [3:0] divCnt;
  wire        halfDone = divCnt == mbrs_pkg::SER_HALF_CYC - 4'h1;

  // =====================================================
  // byte shifter, full duplex
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      active   <= 1'b0;
      tgt      <= 1'b0;
      shiftOut <= 8'h00;
      shiftIn  <= 8'h00;
      bitCnt   <= 3'h0;
      divCnt   <= 4'h0;
      sclk     <= 1'b0;
      rxByte   <= 8'h00;
      rxValid  <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!active) begin
        if (start) begin
          active   <= 1'b1;
          tgt      <= target;
          shiftOut <= txByte;
          bitCnt   <= 3'h0;
          divCnt   <= 4'h0;
        end
      end else if (!halfDone) begin
        divCnt <= divCnt + 4'h1;
      end else begin
        divCnt <= 4'h0;
        sclk   <= ~sclk;
        if (!sclk) begin
          shiftIn <= {shiftIn[6:0], sdi};
        end else begin
          shiftOut <= {shiftOut[6:0], 1'b0};
          bitCnt   <= bitCnt + 3'h1;
          if (bitCnt == 3'h7) begin
            active  <= 1'b0;
            rxByte  <= shiftIn;
            rxValid <= 1'b1;
          end
        end
      end
    end
  end

  assign busy   = active;
  assign selA_n = !(active && !tgt);
  assign selB_n = !(active && tgt);
  assign sdo    = shiftOut[7];

  property p_sel_one;
    @(posedge core_clk) disable iff (!rst_b)
      start && !busy |=> (tgt ? !selB_n && selA_n : !selA_n && selB_n) [*8];
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("wrong driver selected");
endmodule
`default_nettype wire

//--- mbrs_load_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module mbrs_load_tracker (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        rowWrite,
  input  wire logic [10:0] rowAddr,
  input  wire logic [14:0] clearMask,
  output logic [14:0]      loadedMask
);
  // =====================================================
  // rows written per block since its last reset
  genvar gb;
  generate
    for (gb = 0; gb < mbrs_pkg::NUM_BLOCKS; gb++) begin : g_blk
      localparam logic [10:0] LO = 11'(gb * mbrs_pkg::ROWS_PER_BLOCK);
      localparam logic [10:0] HI = 11'(gb * mbrs_pkg::ROWS_PER_BLOCK
                                       + mbrs_pkg::ROWS_PER_BLOCK - 1);
      localparam logic [6:0]  FULL = 7'(mbrs_pkg::ROWS_PER_BLOCK);
      logic [6:0] rowCnt;
      wire        hit = rowWrite && rowAddr >= LO && rowAddr <= HI;
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          rowCnt <= 7'h00;
        end else if (clearMask[gb]) begin
          rowCnt <= hit ? 7'h01 : 7'h00;
        end else if (hit && rowCnt != FULL) begin
          rowCnt <= rowCnt + 7'h01;
        end
      end
      assign loadedMask[gb] = rowCnt == FULL;

      property p_clear;
        @(posedge core_clk) disable iff (!rst_b)
          clearMask[gb] |=> !loadedMask[gb];
      endproperty
      a_clear: assert property (p_clear) else $error("block still loaded after reset");
    end
  endgenerate
endmodule
`default_nettype wire

//--- mbrs_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// two clocking pulse driver chips on the far side
module mbrs_drv_model #(
  parameter logic [7:0] RESP_A = 8'hC3,
  parameter logic [7:0] RESP_B = 8'h5A
) (
  input  wire logic                      core_clk,
  input  wire mbrs_pkg::mbrs_drv_s [1:0] drvCtl,
  input  wire logic                      selA_n,
  input  wire logic                      selB_n,
  input  wire logic                      sclk,
  input  wire logic                      sdin,
  input  wire logic                      irqReq,
  output logic                           sdout,
  output logic                           irq,
  output mbrs_pkg::mbrs_drv_s [1:0]      latched,
  output logic [1:0][7:0]                nStrobe,
  output logic [1:0]                     ctlMoved,
  output logic [1:0][7:0]                rxByte
);
  // =====================================================
  // strobe, select and level latching
  mbrs_pkg::mbrs_drv_s lat [2];
  int                  cnt [2] = '{0, 0};
  logic                moved [2] = '{1'b0, 1'b0};
  for (genvar i = 0; i < 2; i++) begin : g_drv
    always @(posedge drvCtl[i].strobe) begin
      lat[i] <= drvCtl[i];
      cnt[i] <= cnt[i] + 1;
    end
    always @(negedge drvCtl[i].strobe) begin
      if (drvCtl[i][7:0] !== lat[i][7:0]) begin
        moved[i] <= 1'b1;
      end
    end
  end
  // last latched level holds until the next strobe
  assign latched  = {lat[1], lat[0]};
  assign nStrobe  = {8'(cnt[1]), 8'(cnt[0])};
  assign ctlMoved = {moved[1], moved[0]};
  // =====================================================
  // serial port, byte wide, full duplex
  wire        anySelN = selA_n & selB_n;
  logic [7:0] rxSh, rxA, rxB;
  int         nFall = 0;
  int         base = 0;
  logic       tgt = 1'b0;
  logic       idleBit = 1'b0;
  always @(posedge core_clk) idleBit <= ~idleBit;
  always @(negedge sclk) nFall <= nFall + 1;
  always @(negedge anySelN) begin
    base = nFall;
    tgt = selA_n;
  end
  always @(posedge sclk) if (!anySelN) rxSh <= {rxSh[6:0], sdin};
  always @(posedge anySelN) begin
    if (tgt) rxB <= rxSh;
    else rxA <= rxSh;
  end
  wire [7:0] resp = tgt ? RESP_B : RESP_A;
  wire [3:0] idx  = 4'(nFall - base);
  // data back changes after falling clock, toggles when released
  assign sdout  = (!anySelN && idx < 4'h8) ? resp[3'(4'h7 - idx)] : idleBit;
  assign irq    = irqReq;
  assign rxByte = {rxB, rxA};
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // =====================================================
  // signals
  localparam int         INIT   = 20;
  localparam logic [7:0] RESP_A = 8'hC3;
  localparam logic [7:0] RESP_B = 8'h5A;
  logic                      core_clk, rst_b, cmdValid, withRelease, rowWrite, irqReq;
  logic                      serValid, serTarget, cmdAccepted, cmdRejected, irqSeen;
  logic                      resetActive, initActive, pixelVisible, serReady, serRxValid;
  logic                      selA_n, selB_n, sclk, sdin, sdout, irq;
  logic [1:0]                mode, ctlMoved;
  logic [3:0]                ptr, arrayType;
  logic [10:0]               rowAddr, pixelCol;
  logic [7:0]                serByte, serRxByte;
  logic [14:0]               loadedMask;
  logic [1:0][7:0]           nStrobe, rxByte;
  mbrs_pkg::mbrs_drv_s [1:0] drvCtl, latched;
  int                        n_errors, tests_run, cycles, got, cnt [15];
  // =====================================================
  // design and driver chips
  mbrs_sequencer #(.INIT_CYCLES(INIT)) i_mbrs_sequencer (
    .core_clk(core_clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .blockCommandModeSelect(mode), .blockAddressPointer(ptr), .withRelease(withRelease),
    .cmdAccepted(cmdAccepted), .cmdRejected(cmdRejected), .resetActive(resetActive),
    .initActive(initActive), .arrayType(arrayType), .rowWrite(rowWrite), .rowAddr(rowAddr),
    .loadedMask(loadedMask), .pixelCol(pixelCol), .pixelVisible(pixelVisible),
    .serValid(serValid), .serTarget(serTarget), .serByte(serByte), .serReady(serReady),
    .serRxByte(serRxByte), .serRxValid(serRxValid), .driverASerialSelect_n(selA_n),
    .driverBSerialSelect_n(selB_n), .driverSerialClock(sclk), .driverSerialDataIn(sdin),
    .driverSerialDataOut(sdout), .driverIrq(irq), .driverIrqSeen(irqSeen), .drvCtl(drvCtl));
  mbrs_drv_model #(.RESP_A(RESP_A), .RESP_B(RESP_B)) i_mbrs_drv_model (
    .core_clk(core_clk), .drvCtl(drvCtl), .selA_n(selA_n), .selB_n(selB_n), .sclk(sclk),
    .sdin(sdin), .irqReq(irqReq), .sdout(sdout), .irq(irq), .latched(latched),
    .nStrobe(nStrobe), .ctlMoved(ctlMoved), .rxByte(rxByte));
  // =====================================================
  // helpers and reference model
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [14:0] grp(input int m, input int p);
    case (m)
      0: return 15'(1 << p);
      1: return 15'(3 << (p & 14));
      2: return 15'(15 << (p & 12));
      default: return 15'h7FFF;
    endcase
  endfunction
  function automatic logic [14:0] expMask();
    for (int b = 0; b < 15; b++) expMask[b] = cnt[b] >= 72;
  endfunction
  task automatic load(input logic [14:0] m);
    for (int b = 0; b < 15; b++) begin
      for (int r = 0; r < 72 && m[b]; r++) begin
        rowWrite = 1'b1;
        rowAddr = 11'(b * 72 + r);
        tick();
        if (cnt[b] < 72) cnt[b]++;
      end
    end
    rowWrite = 1'b0;
    check(loadedMask === expMask(), "loaded blocks");
  endtask
  task automatic cmd(input int m, input int p, input logic rel, input logic expOk);
    logic [14:0] g;
    int          d [2];
    int          n;
    int          e;
    g = grp(m, p);
    d = '{int'(nStrobe[0]), int'(nStrobe[1])};
    cmdValid = 1'b1;
    mode = 2'(m);
    ptr = 4'(p);
    withRelease = rel;
    #5 check(cmdAccepted === expOk && cmdRejected === !expOk, "accept flag");
    tick();
    cmdValid = 1'b0;
    if (expOk) begin
      for (int b = 0; b < 15; b++) if (g[b]) cnt[b] = 0;
      check(resetActive === 1'b1 && loadedMask === expMask(), "group taken");
      if (rel) load(g);
      for (n = 0; n < 3000 && resetActive === 1'b1; n++) tick();
      check(resetActive === 1'b0, "sequence end");
      e = int'(mbrs_pkg::SETUP_CYC) + int'(mbrs_pkg::STROBE_CYC)
        + int'(arrayType == 4'h3 ? mbrs_pkg::SETTLE_A_CYC : mbrs_pkg::SETTLE_B_CYC);
      if (!rel) check(n == 2 * e, "pulse time");
      for (int k = 0; k < 2; k++) begin
        if (k ? |g[14:8] : |g[7:0]) begin
          check(int'(nStrobe[k]) - d[k] == (rel ? 3 : 2), "strobe count");
          check(latched[k].levelSel === mbrs_pkg::LVL_HOLD, "final level");
          check(latched[k].countSel === 2'(m), "count select");
          if (m == 0) check(latched[k].groupAddr === 4'(k ? p - 8 : p), "address");
        end
      end
    end
    tick();
  endtask
  // =====================================================
  // clock, timeout, main sequence
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles > 20000) begin
        n_errors++;
        $display("[FAIL] %0t timeout", $time);
        conclude();
      end
    end
  end
  initial begin
    {rst_b, cmdValid, withRelease, rowWrite, serValid, serTarget, irqReq} = '0;
    {mode, ptr, rowAddr, pixelCol, serByte} = '0;
    arrayType = 4'h3;
    n_errors = 0;
    tests_run = 0;
    foreach (cnt[b]) cnt[b] = 0;
    void'($urandom(19054));
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    check(initActive === 1'b1, "init flag");
    cmd(0, 0, 1'b1, 1'b0);
    for (int i = 0; i < INIT + 4 && initActive === 1'b1; i++) tick();
    check(initActive === 1'b0, "init end");
    $display("test init done");
    arrayType = 4'h0;
    cmd(0, 3, 1'b1, 1'b0);
    arrayType = 4'h3;
    cmd(0, 5, 1'b0, 1'b0);
    $display("test refusal done");
    for (int m = 0; m < 4; m++) begin
      got = $urandom_range(14, 0);
      arrayType = m[0] ? 4'h5 : 4'h3;
      load(grp(m, got));
      cmd(m, got, 1'b0, 1'b1);
    end
    cmd(1, 14, 1'b1, 1'b1);
    cmd(2, 12, 1'b1, 1'b1);
    $display("test block modes done");
    for (int i = 0; i < 16; i++) begin
      got = i < 6 ? (i < 3 ? 63 + i : 1852 + i) : $urandom_range(1919, 0);
      pixelCol = 11'(got);
      tick();
      check(pixelVisible === (got >= 64 && got < 1856), "visible");
    end
    $display("test pixels done");
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 200 && serReady !== 1'b1; i++) tick();
      got = $urandom_range(255, 0);
      serTarget = t[0];
      serByte = 8'(got);
      serValid = 1'b1;
      tick();
      serValid = 1'b0;
      for (int i = 0; i < 200 && serRxValid !== 1'b1; i++) tick();
      check(serRxByte === (t ? RESP_B : RESP_A), "byte back");
      tick(4);
      check(rxByte[t] === 8'(got), "byte out");
    end
    irqReq = 1'b1;
    for (int i = 0; i < 4 && irqSeen !== 1'b1; i++) tick();
    check(irqSeen === 1'b1, "irq seen");
    irqReq = 1'b0;
    $display("test serial done");
    check(ctlMoved === 2'b00, "lines stable");
    conclude();
  end
endmodule
`default_nettype wire
